// [hdl/fsr_top.sv]
// status, tape register and rate select logic of the disk controller
// assumes an axi4-lite master on mclk and a command engine on mclk
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "fsr_params.svh"

module fsr_top
    import fsr_pkg::*;
#(
    parameter int READY_NS = `FSR_READY_NS,  // ready deadline in ns
    parameter int CLK_MHZ  = `FSR_CLK_MHZ    // mclk rate in MHz
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    // axi4-lite slave
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // command engine side
    input  wire fsr_core_s   core,
    output logic             host_wr,
    output logic             host_rd,
    output logic [7:0]       host_byte,
    output logic             soft_reset,
    // media sense and drive id pins, asynchronous
    input  wire logic [5:0]  media_pins,
    output fsr_drive_s       drive
);
    // longest wait rounds down, never below one cycle
    localparam int RDY_CYC = (READY_NS * CLK_MHZ) / 1000;
    localparam int RDY_A   = RDY_CYC + 2;

    // refuse counts the startup counter cannot hold
    if (RDY_CYC < 1 || RDY_CYC > 255) begin : g_chk
        $error("fsr_top: ready count out of range");
    end

    logic [7:0]  init_cnt;     // startup countdown
    logic        init_busy;    // status held at 00h
    logic        request_for_master;          // request for master
    logic        cip;          // command in progress
    logic [3:0]  busy;         // per-drive seek busy
    logic [2:0]  pre_code;     // stored precomp code
    logic [1:0]  rate_code;    // last written rate code
    logic        lp;           // manual low power
    logic [31:0] cfg;          // own config register
    logic [1:0]  tape_sel;     // tape select bits
    logic [1:0]  swap;         // drive exchange bits
    logic [5:0]  pin_s1;       // first sync stage
    logic [5:0]  pin_s2;       // second sync stage
    logic [7:0]  aw_addr;      // held write address
    logic [31:0] w_data;       // held write data
    logic [3:0]  w_strb;       // held write strobes
    logic        aw_got;       // address held
    logic        w_got;        // data held
    logic        do_wr;        // both halves held
    logic        ar_fire;      // read address taken
    logic        wr_ok;        // write decodes to a register
    logic        lane0;        // low byte lane enabled
    logic [7:0]  msr_val;      // status value as read
    logic [7:0]  tdr_val;      // tape register as read
    logic [31:0] rd_val;       // read mux
    logic        rd_ok;        // read decodes to a register
    logic        dat_acc;      // data port access this cycle
    logic        msr_rd;       // status read this cycle
    logic        dsr_wr;       // rate select write this cycle
    logic        ccr_wr;       // ccr write this cycle
    logic        sw_rst_req;   // rate select bit 7 written

    // address decode used by both read and write paths
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `FSR_OFF_STATUS) || (a == `FSR_OFF_RATESEL)
                 || (a == `FSR_OFF_TAPE)   || (a == `FSR_OFF_CCR)
                 || (a == `FSR_OFF_DATA)   || (a == `FSR_OFF_CFG);
    endfunction : is_mapped

    // rate code decode
    // rate code to rate, test mode allows only 2 Mbps
    function automatic fsr_rate_e rate_of(input logic [1:0] c,
                                          input logic       t);
        if (t) begin
            rate_of = (c == 2'h3) ? FSR_RATE_2M : FSR_RATE_BAD;
        end else begin
            case (c)
                2'h3:    rate_of = FSR_RATE_1M;
                2'h0:    rate_of = FSR_RATE_500K;
                2'h1:    rate_of = FSR_RATE_300K;
                default: rate_of = FSR_RATE_250K;
            endcase
        end
    endfunction : rate_of

    // strobes of the current bus cycle
    assign do_wr   = aw_got && w_got && !s_bvalid;
    assign ar_fire = s_arvalid && s_arready;
    assign lane0   = w_strb[0];
    assign wr_ok   = is_mapped(aw_addr);
    assign rd_ok   = is_mapped(s_araddr);
    assign dsr_wr  = do_wr && lane0 && (aw_addr == `FSR_OFF_RATESEL);
    assign ccr_wr  = do_wr && lane0 && (aw_addr == `FSR_OFF_CCR);
    assign msr_rd  = ar_fire && (s_araddr == `FSR_OFF_STATUS);
    assign dat_acc = (ar_fire && (s_araddr == `FSR_OFF_DATA))
                  || (do_wr && lane0 && (aw_addr == `FSR_OFF_DATA));
    assign sw_rst_req = dsr_wr && w_data[`FSR_DSR_SWRST];

    // pins pass two flops before any logic looks at them
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pin_s1 <= 6'h00;
            pin_s2 <= 6'h00;
        end else begin
            pin_s1 <= media_pins;
            pin_s2 <= pin_s1;
        end
    end

    // write channel: address and data taken in either order
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            aw_addr   <= 8'h00;
            w_data    <= 32'h0000_0000;
            w_strb    <= 4'h0;
            s_bvalid  <= 1'b0;
            s_bresp   <= `FSR_RESP_OKAY;
        end else begin
            s_awready <= !aw_got && !(s_awvalid && s_awready);
            s_wready  <= !w_got && !(s_wvalid && s_wready);
            if (s_awvalid && s_awready) begin
                aw_got  <= 1'b1;
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_got  <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            // unmapped address answers slverr
            if (do_wr) begin
                s_bvalid <= 1'b1;
                s_bresp  <= wr_ok ? `FSR_RESP_OKAY : `FSR_RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                aw_got    <= 1'b0;
                w_got     <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    // read channel: one read at a time, answer next cycle
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= `FSR_RESP_OKAY;
        end else if (ar_fire) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rdata   <= rd_val;
            s_rresp   <= rd_ok ? `FSR_RESP_OKAY : `FSR_RESP_SLVERR;
        end else if (s_rvalid && s_rready) begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
        end else begin
            s_arready <= !s_rvalid;
        end
    end

    // status is zero while the controller settles
    always_comb begin
        if (init_busy) begin
            msr_val = 8'h00;
        end else begin
            // request follows interrupt in non-dma execution
            // direction and non-dma bits from engine
            msr_val = {(core.nondma ? core.irq : request_for_master),
                       core.dir_rd, core.nondma, cip, busy};
        end
    end

    // tape register layout by config mode
    always_comb begin
        tdr_val = {6'h00, tape_sel};
        if (cfg[`FSR_CFG_AUTO]) begin
            tdr_val = {pin_s2[5:4], pin_s2[1:0], swap, tape_sel};
        end else if (!cfg[`FSR_CFG_CTRL]) begin
            // valid bit from the sense of active drive 0 or 1, set for drives 2 and 3
            tdr_val[7:6] = pin_s2[5:4];
            case (core.act_drv)
                2'h0:    tdr_val[5] = pin_s2[2];
                2'h1:    tdr_val[5] = pin_s2[3];
                default: tdr_val[5] = 1'b1;
            endcase
        end
    end

    // read mux; write-only registers read as zero
    always_comb begin
        case (s_araddr)
            `FSR_OFF_STATUS: rd_val = {24'h000000, msr_val};
            `FSR_OFF_TAPE:   rd_val = {24'h000000, tdr_val};
            `FSR_OFF_DATA:   rd_val = {24'h000000, core.res_byte};
            `FSR_OFF_CFG:    rd_val = cfg;
            default:         rd_val = 32'h0000_0000;
        endcase
    end

    // startup countdown after reset, soft reset or wake
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            init_cnt  <= 8'(RDY_CYC);
            init_busy <= 1'b1;
        end else if (sw_rst_req || (lp && (dat_acc || msr_rd))) begin
            init_cnt  <= 8'(RDY_CYC);
            init_busy <= 1'b1;
        end else if (init_busy) begin
            init_cnt  <= init_cnt - 8'h01;
            init_busy <= (init_cnt != 8'h01);
        end
    end

    // request bit: the ready event wins over a transfer
    always_ff @(posedge mclk) begin
        if (!nrst || sw_rst_req) begin
            request_for_master <= 1'b0;
        end else if (init_busy) begin
            request_for_master <= (init_cnt == 8'h01);
        end else if (core.byte_ready) begin
            request_for_master <= 1'b1;
        end else if (dat_acc) begin
            request_for_master <= 1'b0;
        end
    end

    // command busy, a new command wins over the clear
    always_ff @(posedge mclk) begin
        if (!nrst || sw_rst_req) begin
            cip <= 1'b0;
        end else if (core.cmd_first) begin
            cip <= 1'b1;
        end else if (core.res_last || core.cmd_end_nr) begin
            cip <= 1'b0;
        end
    end

    // per-drive busy, set beats clear on the same drive
    for (genvar i = 0; i < 4; i++) begin : g_busy
        always_ff @(posedge mclk) begin
            if (!nrst || sw_rst_req) begin
                busy[i] <= 1'b0;
            end else if (core.seek_cmd && core.drv == 2'(i)) begin
                busy[i] <= 1'b1;
            end else if (core.sense_first && core.drv == 2'(i)) begin
                busy[i] <= 1'b0;
            end
        end
    end

    // rate select loads 02h on hardware reset only
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pre_code  <= 3'(`FSR_DSR_RESET >> `FSR_DSR_PRE_LSB);
            rate_code <= 2'(`FSR_DSR_RESET);
        end else begin
            if (dsr_wr) begin
                pre_code <= w_data[`FSR_DSR_PRE_LSB +: 3];
            end
            // last write to either register sets the rate
            if (dsr_wr || ccr_wr) begin
                rate_code <= w_data[1:0];
            end
        end
    end

    // soft reset is a one-cycle self-clearing pulse
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= sw_rst_req;
        end
    end

    // manual low power, wake takes priority
    always_ff @(posedge mclk) begin
        if (!nrst || sw_rst_req || dat_acc || msr_rd) begin
            lp <= 1'b0;
        end else if (dsr_wr && w_data[`FSR_DSR_LOWPWR]) begin
            lp <= 1'b1;
        end
    end

    // config and tape register writes, byte lanes honoured
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cfg      <= `FSR_CFG_RESET;
            tape_sel <= 2'h0;
            swap     <= 2'h0;
        end else if (do_wr) begin
            if (aw_addr == `FSR_OFF_CFG) begin
                for (int b = 0; b < 4; b++) begin
                    if (w_strb[b]) begin
                        cfg[8*b +: 8] <= w_data[8*b +: 8];
                    end
                end
            end
            // tape select, swap only in enhanced layout
            if (lane0 && aw_addr == `FSR_OFF_TAPE) begin
                tape_sel <= w_data[1:0];
                if (cfg[`FSR_CFG_AUTO]) begin
                    swap <= w_data[3:2];
                end
            end
        end
    end

    // data port strobes towards the command engine
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            host_wr   <= 1'b0;
            host_rd   <= 1'b0;
            host_byte <= 8'h00;
        end else begin
            host_wr <= do_wr && lane0 && (aw_addr == `FSR_OFF_DATA);
            host_rd <= ar_fire && (s_araddr == `FSR_OFF_DATA);
            if (do_wr && lane0 && aw_addr == `FSR_OFF_DATA) begin
                host_byte <= w_data[7:0];
            end
        end
    end

    // drive-side settings, all registered
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            drive <= '0;
        end else begin
            drive.rate      <= rate_of(rate_code, cfg[`FSR_CFG_TEST]);
            drive.pre_track <= cfg[`FSR_CFG_TRK_LSB +: 8];
            drive.tape_sel  <= tape_sel;
            drive.low_power <= lp;
            drive.exchange  <= cfg[`FSR_CFG_FOURDRV] ? 2'h0 : swap;
            // code steps, doubled units at 24 MHz
            if (pre_code == 3'h7) begin
                drive.precomp <= 4'h0;
            end else if (pre_code != 3'h0) begin
                drive.precomp <= cfg[`FSR_CFG_CLK48]
                               ? {1'b0, pre_code} : {pre_code, 1'b0};
            end else if (rate_code == 2'h3 && cfg[`FSR_CFG_TEST]) begin
                drive.precomp <= `FSR_PRE_2M;
            end else if (rate_code == 2'h3) begin
                drive.precomp <= `FSR_PRE_1M;
            end else begin
                drive.precomp <= `FSR_PRE_SLOW;
            end
        end
    end

    msr_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
        msr_rd && init_busy |=> s_rdata == 32'h0000_0000)
        else $error("status not zero while settling");

    ready_time_a: assert property (@(posedge mclk)
        $rose(nrst) |-> ##[1:RDY_A] (msr_val == `FSR_MSR_READY
                                      || core.cmd_first || cip))
        else $error("ready value late after reset");

    // transfer without ready event drops the request
    rqm_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
        dat_acc && !core.byte_ready && !init_busy && !sw_rst_req
        && !lp |=> !request_for_master)
        else $error("request bit kept after transfer");

    rqm_irq_a: assert property (@(posedge mclk) disable iff (!nrst)
        msr_rd && !init_busy && core.nondma
        |=> s_rdata[7] == $past(core.irq))
        else $error("request bit not following interrupt");

    cip_set_a: assert property (@(posedge mclk) disable iff (!nrst)
        core.cmd_first && !sw_rst_req |=> cip)
        else $error("command busy not set");

    // sense read clears the drive busy bit
    busy_clr_a: assert property (@(posedge mclk) disable iff (!nrst)
        core.sense_first && !core.seek_cmd |=> !busy[$past(core.drv)])
        else $error("drive busy not cleared");

    // soft reset keeps rate select contents
    dsr_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
        sw_rst_req |=> (pre_code == $past(w_data[`FSR_DSR_PRE_LSB +: 3])
                        && rate_code == $past(w_data[1:0]))
                       ##1 ($stable(pre_code) && $stable(rate_code)))
        else $error("rate select changed by soft reset");

    swrst_pulse_a: assert property (@(posedge mclk) disable iff (!nrst)
        sw_rst_req |=> soft_reset ##1 !soft_reset)
        else $error("soft reset not self-clearing");

    // status read wakes from low power
    lp_wake_a: assert property (@(posedge mclk) disable iff (!nrst)
        lp && msr_rd |=> !lp ##1 !drive.low_power)
        else $error("low power not left on status read");

    // normal code 00 maps to 500 kbps
    rate_map_a: assert property (@(posedge mclk) disable iff (!nrst)
        ccr_wr && !cfg[`FSR_CFG_TEST] && w_data[1:0] == 2'h0
        |=> ##1 drive.rate == FSR_RATE_500K)
        else $error("rate code 00 not 500 kbps");

endmodule : fsr_top

// [include/fsr_params.svh]
// constants of the floppy status and rate control block
// assumes inclusion by fsr_pkg, fsr_top and tb_top only
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

// register byte offsets on the lite bus
`define FSR_OFF_STATUS   8'h00
`define FSR_OFF_RATESEL  8'h04
`define FSR_OFF_TAPE     8'h08
`define FSR_OFF_CCR      8'h0c
`define FSR_OFF_DATA     8'h10
`define FSR_OFF_CFG      8'h14

// rate select register fields
`define FSR_DSR_SWRST    7
`define FSR_DSR_LOWPWR   6
`define FSR_DSR_PRE_LSB  2
`define FSR_DSR_RESET    8'h02

// config register fields
`define FSR_CFG_CTRL     0
`define FSR_CFG_TEST     1
`define FSR_CFG_AUTO     2
`define FSR_CFG_FOURDRV  3
`define FSR_CFG_CLK48    4
`define FSR_CFG_TRK_LSB  8
`define FSR_CFG_RESET    32'h0000_0001

// status register values and timing
`define FSR_MSR_READY    8'h80
`define FSR_READY_NS     2500
`define FSR_CLK_MHZ      10

// default precompensation in 20.8 ns units
`define FSR_PRE_2M       4'h1
`define FSR_PRE_1M       4'h2
`define FSR_PRE_SLOW     4'h6

// bus responses
`define FSR_RESP_OKAY    2'h0
`define FSR_RESP_SLVERR  2'h2

`endif

// [include/fsr_pkg.sv]
// types of the floppy status and rate control block
// assumes fsr_params.svh on the include path
`include "fsr_params.svh"
package fsr_pkg;
    // decoded active data rate
    typedef enum logic [2:0] {
        FSR_RATE_250K, FSR_RATE_300K, FSR_RATE_500K,
        FSR_RATE_1M,   FSR_RATE_2M,   FSR_RATE_BAD
    } fsr_rate_e;

    // events and levels from the command engine, same clock
    typedef struct packed {
        logic       cmd_first;   // first command byte taken
        logic       cmd_end_nr;  // last command byte, no result phase
        logic       res_last;    // last result byte read
        logic       seek_cmd;    // seek or recalibrate issued
        logic       sense_first; // first sense-interrupt result read
        logic [1:0] drv;         // drive of seek or sense event
        logic [1:0] act_drv;     // drive currently accessed
        logic       byte_ready;  // next byte can be exchanged
        logic       dir_rd;      // host should read next byte
        logic       nondma;      // non-dma execution phase
        logic       irq;         // controller interrupt level
        logic [7:0] res_byte;    // byte offered to the host
    } fsr_core_s;

    // settings handed to the drive side
    typedef struct packed {
        fsr_rate_e  rate;        // active data rate
        logic [3:0] precomp;     // delay in 20.8 ns units
        logic [7:0] pre_track;   // first precompensated track
        logic [1:0] tape_sel;    // logical tape drive
        logic [1:0] exchange;    // effective drive exchange
        logic       low_power;   // oscillator and separator off
    } fsr_drive_s;
endpackage : fsr_pkg

// [bench/fsr_host.sv]
// host processor model: lite bus master with word write and read tasks
// assumes a slave on mclk that answers with its own ready and valid
`timescale 1ns/1ps
module fsr_host
    import fsr_pkg::*;
(
    input  wire logic        mclk,
    output logic [7:0]       s_awaddr,
    output logic             s_awvalid,
    input  wire logic        s_awready,
    output logic [31:0]      s_wdata,
    output logic [3:0]       s_wstrb,
    output logic             s_wvalid,
    input  wire logic        s_wready,
    input  wire logic [1:0]  s_bresp,
    input  wire logic        s_bvalid,
    output logic             s_bready,
    output logic [7:0]       s_araddr,
    output logic             s_arvalid,
    input  wire logic        s_arready,
    input  wire logic [31:0] s_rdata,
    input  wire logic [1:0]  s_rresp,
    input  wire logic        s_rvalid,
    output logic             s_rready
);
    // idle bus from time zero
    initial begin
        {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
        {s_araddr, s_arvalid, s_rready} = '0;
    end

    // both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge mclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= 4'hf;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while ((s_awvalid && !s_awready) || (s_wvalid && !s_wready));
        while (s_bvalid !== 1'b1) @(posedge mclk);
        r = s_bresp;
        s_bready <= 1'b0;
    endtask : wr

    // address held until taken, data taken at the valid edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge mclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge mclk); while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        while (s_rvalid !== 1'b1) @(posedge mclk);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
    endtask : rd
endmodule : fsr_host

// [bench/tb_top.sv]
// bench: register traffic through the host model, engine events scripted
// assumes fsr_host and fsr_top with default parameters
`timescale 1ns/1ps
`include "fsr_params.svh"
module tb_top
    import fsr_pkg::*;
;
    logic        mclk, nrst, s_awvalid, s_awready, s_wvalid, s_wready;
    logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid;
    logic        s_rready, host_wr, host_rd, soft_reset;
    logic [7:0]  s_awaddr, s_araddr, host_byte;
    logic [31:0] s_wdata, s_rdata, rd;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp, rs;
    logic [5:0]  media_pins;
    fsr_core_s   core, base, p;
    fsr_drive_s  drive;
    int          fails, checks_done, cyc, nwr, nsr, nrd;
    // rate per code with test mode off
    fsr_rate_e   rmap[4] = '{FSR_RATE_500K, FSR_RATE_300K,
                             FSR_RATE_250K, FSR_RATE_1M};

    fsr_top uut (.*);
    fsr_host host (.*);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // pulse counters and hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (host_wr === 1'b1) nwr <= nwr + 1;
        if (host_rd === 1'b1) nrd <= nrd + 1;
        if (soft_reset === 1'b1) nsr <= nsr + 1;
        if (cyc > 6000) begin
            fails++;
            stop_test();
        end
    end

    task automatic cmp(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : cmp

    task automatic stop_test();
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic st();
        host.rd(`FSR_OFF_STATUS, rd, rs);
    endtask : st

    // one register write, then time for the drive settings to land
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        host.wr(a, d, rs);
        repeat (3) @(posedge mclk);
    endtask : w

    // one-cycle engine event on top of the current levels
    task automatic ev(input fsr_core_s v);
        @(posedge mclk);
        core <= v;
        @(posedge mclk);
        core <= base;
    endtask : ev

    initial begin
        {nrst, fails, checks_done, cyc, nwr, nsr, nrd} = '0;
        base = '0;
        core = '0;
        // extra density, drive 1 valid, drive id 10
        media_pins = 6'b101010;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        st();
        cmp("status settling", 32'h0, rd);
        repeat (25) @(posedge mclk);
        st();
        cmp("status ready", `FSR_MSR_READY, rd);
        host.rd(`FSR_OFF_RATESEL, rd, rs);
        cmp("rate select read", 32'h0, rd);
        cmp("reset rate", FSR_RATE_250K, drive.rate);
        cmp("reset precomp", `FSR_PRE_SLOW, drive.precomp);
        for (int c = 0; c < 4; c++) begin
            w(`FSR_OFF_RATESEL, 32'(c));
            cmp("rate", rmap[c], drive.rate);
            cmp("auto precomp", c == 3 ? 2 : 6, drive.precomp);
        end
        for (int n = 1; n < 8; n++) begin
            w(`FSR_OFF_RATESEL, 32'(n * 4 + 2));
            cmp("precomp", n == 7 ? 0 : 2 * n, drive.precomp);
        end
        cmp("start track", 32'h0, drive.pre_track);
        // 48 MHz clock, start track moved to 5
        w(`FSR_OFF_CFG, 32'h0511);
        w(`FSR_OFF_RATESEL, 32'h0e);
        cmp("precomp 48", 32'h3, drive.precomp);
        cmp("moved track", 32'h5, drive.pre_track);
        w(`FSR_OFF_CCR, 32'h0);
        cmp("ccr rate", FSR_RATE_500K, drive.rate);
        w(`FSR_OFF_RATESEL, 32'h1);
        cmp("dsr after ccr", FSR_RATE_300K, drive.rate);
        w(`FSR_OFF_CFG, 32'h3);
        w(`FSR_OFF_RATESEL, 32'h3);
        cmp("test rate", FSR_RATE_2M, drive.rate);
        cmp("test precomp", `FSR_PRE_2M, drive.precomp);
        w(`FSR_OFF_CFG, 32'h1);
        w(`FSR_OFF_RATESEL, 32'h81);
        cmp("soft reset pulses", 32'h1, nsr);
        cmp("rate kept", FSR_RATE_300K, drive.rate);
        st();
        cmp("status after soft reset", 32'h0, rd);
        w(`FSR_OFF_RATESEL, 32'h41);
        cmp("low power on", 32'h1, drive.low_power);
        st();
        repeat (3) @(posedge mclk);
        cmp("low power off", 32'h0, drive.low_power);
        repeat (30) @(posedge mclk);
        p = base;
        p.cmd_first = 1'b1;
        ev(p);
        st();
        cmp("cmd busy set", 32'h1, rd[4]);
        p = base;
        p.seek_cmd = 1'b1;
        p.drv = 2'd2;
        ev(p);
        st();
        cmp("drive busy set", 32'h4, rd[3:0]);
        p.seek_cmd = 1'b0;
        p.sense_first = 1'b1;
        ev(p);
        st();
        cmp("drive busy clear", 32'h0, rd[3:0]);
        p = base;
        p.res_last = 1'b1;
        ev(p);
        st();
        cmp("cmd busy clear", 32'h0, rd[4]);
        p = base;
        p.cmd_first = 1'b1;
        ev(p);
        p = base;
        p.cmd_end_nr = 1'b1;
        ev(p);
        st();
        cmp("no result clear", 32'h0, rd[4]);
        host.wr(`FSR_OFF_DATA, 32'h5a, rs);
        repeat (2) @(posedge mclk);
        cmp("data byte", 32'h5a, host_byte);
        cmp("data strobes", 32'h1, nwr);
        st();
        cmp("rqm cleared", 32'h0, rd[7]);
        p = base;
        p.byte_ready = 1'b1;
        ev(p);
        st();
        cmp("rqm set", 32'h1, rd[7]);
        base.nondma = 1'b1;
        base.dir_rd = 1'b1;
        ev(base);
        st();
        cmp("exec status", 32'h3, rd[7:5]);
        base.irq = 1'b1;
        ev(base);
        st();
        cmp("rqm follows irq", 32'h1, rd[7]);
        base.res_byte = 8'ha5;
        ev(base);
        host.rd(`FSR_OFF_DATA, rd, rs);
        cmp("data read", 32'ha5, rd);
        base = '0;
        ev(base);
        cmp("read strobes", 32'h1, nrd);
        w(`FSR_OFF_CFG, 32'h0);
        w(`FSR_OFF_TAPE, 32'h3);
        host.rd(`FSR_OFF_TAPE, rd, rs);
        cmp("media sense", 32'h4, rd[7:5]);
        cmp("tape select", 32'h3, rd[1:0]);
        w(`FSR_OFF_CFG, 32'h1);
        host.rd(`FSR_OFF_TAPE, rd, rs);
        cmp("compat tape", 32'h3, rd[1:0]);
        w(`FSR_OFF_CFG, 32'h4);
        w(`FSR_OFF_TAPE, 32'h7);
        host.rd(`FSR_OFF_TAPE, rd, rs);
        cmp("enhanced tape", 32'h27, rd[5:0]);
        cmp("tape drive", 32'h3, drive.tape_sel);
        cmp("exchange", 32'h1, drive.exchange);
        w(`FSR_OFF_CFG, 32'hc);
        cmp("four-drive exchange", 32'h0, drive.exchange);
        host.wr(8'h40, 32'h1, rs);
        cmp("unmapped write", `FSR_RESP_SLVERR, rs);
        host.rd(8'h40, rd, rs);
        cmp("unmapped read", `FSR_RESP_SLVERR, rs);
        stop_test();
    end
endmodule : tb_top
